/* verilog/lsd_pkg.sv */
package lsd_pkg;

   // Register offsets on the die-to-die register port
   localparam logic [7:0] LSD_OFS_CONTROL = 8'h30;
   localparam logic [7:0] LSD_OFS_STATUS  = 8'h31;
   localparam logic [7:0] LSD_OFS_UNLOCK  = 8'h32;

   // Unlock key value that opens driver control
   localparam logic [3:0] LSD_UNLOCK_KEY  = 4'h5;

   // Control register field positions
   localparam int LSD_CTL_DRV1_EN     = 0;
   localparam int LSD_CTL_DRV2_EN     = 1;
   localparam int LSD_CTL_DRV1_PWM_EN = 2;
   localparam int LSD_CTL_DRV2_PWM_EN = 3;
   localparam int LSD_CTL_DRV1_SEL    = 4;
   localparam int LSD_CTL_DRV2_SEL    = 5;
   localparam int LSD_CTL_OT_IRQ_EN   = 7;

   // Status register field positions
   localparam int LSD_ST_DRV1_OL = 0;
   localparam int LSD_ST_DRV2_OL = 1;
   localparam int LSD_ST_DRV1_CL = 2;
   localparam int LSD_ST_DRV2_CL = 3;
   localparam int LSD_ST_OT      = 7;

   // Values after reset and writable bits
   localparam logic [7:0] LSD_CONTROL_RESET = 8'h00;
   localparam logic [7:0] LSD_CONTROL_WMASK = 8'hBF;
   localparam logic [3:0] LSD_UNLOCK_RESET  = 4'h0;
   localparam logic [7:0] LSD_RDATA_RESET   = 8'h00;

   // Overtemperature protection states
   typedef enum logic [1:0] {
      LSD_PROT_RUN      = 2'b00,
      LSD_PROT_OT_HOT   = 2'b01,
      LSD_PROT_OT_WAIT  = 2'b10
   } lsd_prot_t;

endpackage

/* verilog/lsd_onset_flag.sv */
`timescale 1ns/1ps
module lsd_onset_flag (
   // Clock and reset
   input  logic sys_clk,
   input  logic rst_b,
   // Condition and flag control
   input  logic cond,
   input  logic set_en,
   input  logic clear,
   // Results
   output logic onset,
   output logic flag
);

   typedef struct packed {
      logic prev;
      logic flag;
   } lsd_onset_state_t;

   lsd_onset_state_t state_q;
   lsd_onset_state_t state_d;

   // Rising edge of the condition only; a held condition never re-arms
   assign onset = cond & ~state_q.prev;
   assign flag  = state_q.flag;

   // Set beats clear so an onset in the clearing cycle survives
   always_comb begin
      state_d      = state_q;
      state_d.prev = cond;
      state_d.flag = (onset & set_en) | (state_q.flag & ~clear);
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

endmodule

/* verilog/lsd_drv_status.sv */
`timescale 1ns/1ps
module lsd_drv_status (
   // Clock and reset
   input  logic sys_clk,
   input  logic rst_b,
   // Driver state and analog indications
   input  logic drv_on,
   input  logic open_load_raw,
   input  logic current_limit_raw,
   // Qualified status
   output logic open_load,
   output logic current_limited
);

   typedef struct packed {
      logic open_load;
      logic current_limited;
   } lsd_drv_state_t;

   lsd_drv_state_t state_q;
   lsd_drv_state_t state_d;

   // Open-load sensing is blind while the driver is off, PWM off phase too
   always_comb begin
      state_d                 = state_q;
      state_d.open_load       = open_load_raw & drv_on;
      state_d.current_limited = current_limit_raw;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign open_load       = state_q.open_load;
   assign current_limited = state_q.current_limited;

endmodule

/* verilog/lsd_top.sv */
`timescale 1ns/1ps
module lsd_top (
   // Clock and reset
   input  logic       sys_clk,
   input  logic       rst_b,
   // Die-to-die register port
   input  logic [7:0] reg_addr,
   input  logic       reg_wr,
   input  logic       reg_rd,
   input  logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Operating mode
   input  logic       normal_mode,
   // Analog protection and sense indications
   input  logic       overtemp_raw,
   input  logic       drv1_open_load_raw,
   input  logic       drv2_open_load_raw,
   input  logic       drv1_current_limit_raw,
   input  logic       drv2_current_limit_raw,
   // Shared PWM channels
   input  logic       pwm_ch0,
   input  logic       pwm_ch1,
   // Voltage status side
   input  logic       regulator_overvoltage,
   input  logic       regulator_overvoltage_irq_en,
   input  logic       vsr_cond_read,
   output logic       regulator_overvoltage_cond,
   output logic       regulator_overvoltage_irq,
   // Interrupt module side
   input  logic       sink_irq_mask_bit,
   output logic       sink_overtemp_irq_flag,
   output logic       sink_irq_req,
   // Driver gates and unlock indication
   output logic       drv1_out,
   output logic       drv2_out,
   output logic       control_unlocked
);

   // Top-level registered state in one word; the flag and status instances keep their own
   typedef struct packed {
      logic [7:0]         ctrl;
      logic [3:0]         key;
      lsd_pkg::lsd_prot_t prot;
      logic [7:0]         rdata;
      logic               drv1;
      logic               drv2;
      logic               ov_cond;
      logic               ov_irq;
      logic               ot_irq;
   } lsd_top_state_t;

   // Present and next state
   lsd_top_state_t state_q;
   lsd_top_state_t state_d;

   // Decoded register strobes
   logic       wr_control;
   logic       wr_unlock;
   logic       rd_status;
   // Permission terms
   logic       key_ok;
   logic       drive_allowed;
   // Flag module results
   logic       ov_onset;
   logic       ov_flag;
   logic       ot_flag;
   // Qualified driver status
   logic       drv1_ol;
   logic       drv2_ol;
   logic       drv1_cl;
   logic       drv2_cl;
   logic [7:0] status_word;

   // PWM gate for one driver: pass-through when PWM is off
   function automatic logic lsd_pwm_gate(input logic pwm_en, input logic sel,
                                         input logic ch0, input logic ch1);
      logic ch;
      ch = sel ? ch1 : ch0;
      return pwm_en ? ch : 1'b1;
   endfunction

   // Gate for one driver from its enable and the shared conditions
   function automatic logic lsd_drive(input logic en, input logic allowed, input logic pwm_ok);
      return en & allowed & pwm_ok;
   endfunction

   // Strobe qualified by an exact offset; writes elsewhere fall away
   function automatic logic lsd_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
      return strobe & (addr == ofs);
   endfunction

   // Address decode of the register strobes
   // Status offset takes no write; a stray write there is dropped
   assign wr_control = lsd_hit(reg_wr, reg_addr, lsd_pkg::LSD_OFS_CONTROL);
   assign wr_unlock  = lsd_hit(reg_wr, reg_addr, lsd_pkg::LSD_OFS_UNLOCK);
   assign rd_status  = lsd_hit(reg_rd, reg_addr, lsd_pkg::LSD_OFS_STATUS);

   // Only the exact key opens control
   // All four bits compared, so a partial or stray write never unlocks
   assign key_ok = (state_q.key == lsd_pkg::LSD_UNLOCK_KEY);

   // Common permission: key, no thermal or supply fault, Normal mode
   // Faults act on the live inputs, so the very next gate update is blocked
   assign drive_allowed = key_ok
                        & (state_q.prot == lsd_pkg::LSD_PROT_RUN)
                        & ~overtemp_raw
                        & ~regulator_overvoltage
                        & normal_mode;

   // Overvoltage onset detector and interrupt flag
   // Enable sampled at onset only; enabling later raises no late interrupt
   lsd_onset_flag u_ov_flag (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .cond    (regulator_overvoltage),
      .set_en  (regulator_overvoltage_irq_en),
      .clear   (vsr_cond_read),
      .onset   (ov_onset),
      .flag    (ov_flag)
   );

   // Overtemperature source latch for the interrupt module
   // Latched whatever the mask; masking only gates the request
   lsd_onset_flag u_ot_flag (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .cond    (overtemp_raw),
      .set_en  (1'b1),
      .clear   (rd_status),
      .onset   (),
      .flag    (ot_flag)
   );

   // Per-driver status qualification
   // Open load gated by the registered gate, not the enable bit, so PWM off phases stay quiet; current limit is not gated
   lsd_drv_status u_drv1_status (
      .sys_clk           (sys_clk),
      .rst_b             (rst_b),
      .drv_on            (state_q.drv1),
      .open_load_raw     (drv1_open_load_raw),
      .current_limit_raw (drv1_current_limit_raw),
      .open_load         (drv1_ol),
      .current_limited   (drv1_cl)
   );

   // Second driver mirrors the first
   lsd_drv_status u_drv2_status (
      .sys_clk           (sys_clk),
      .rst_b             (rst_b),
      .drv_on            (state_q.drv2),
      .open_load_raw     (drv2_open_load_raw),
      .current_limit_raw (drv2_current_limit_raw),
      .open_load         (drv2_ol),
      .current_limited   (drv2_cl)
   );

   // Status word assembly; unused bits read as zero
   // Bit 7 is live; bits 3:0 lag their raw inputs by one cycle
   always_comb begin
      status_word                         = 8'h00;
      status_word[lsd_pkg::LSD_ST_OT]     = overtemp_raw;
      status_word[lsd_pkg::LSD_ST_DRV2_CL] = drv2_cl;
      status_word[lsd_pkg::LSD_ST_DRV1_CL] = drv1_cl;
      status_word[lsd_pkg::LSD_ST_DRV2_OL] = drv2_ol;
      status_word[lsd_pkg::LSD_ST_DRV1_OL] = drv1_ol;
   end

   // Next state of registers, protection and drivers
   // Later assignments win, so hardware faults come after software writes
   always_comb begin
      state_d = state_q;

      // Control register write; bit 6 stays zero
      if (wr_control) begin
         state_d.ctrl = reg_wdata & lsd_pkg::LSD_CONTROL_WMASK;
      end
      // Supply fault wins over a write to the enables
      if (regulator_overvoltage) begin
         state_d.ctrl[lsd_pkg::LSD_CTL_DRV1_EN] = 1'b0;
         state_d.ctrl[lsd_pkg::LSD_CTL_DRV2_EN] = 1'b0;
      end

      // Key write; an overvoltage onset relocks so software must rewrite it
      if (wr_unlock) begin
         state_d.key = reg_wdata[3:0];
      end
      if (ov_onset) begin
         state_d.key = lsd_pkg::LSD_UNLOCK_RESET;
      end

      // Thermal shutdown holds until a control write after cooling
      // Hot: fault present; wait: cooled but still off until control is written
      // A write while still hot is ignored, so software cannot fight the fault
      case (state_q.prot)
         lsd_pkg::LSD_PROT_RUN: begin
            if (overtemp_raw) begin
               state_d.prot = lsd_pkg::LSD_PROT_OT_HOT;
            end
         end
         lsd_pkg::LSD_PROT_OT_HOT: begin
            if (!overtemp_raw) begin
               state_d.prot = lsd_pkg::LSD_PROT_OT_WAIT;
            end
         end
         lsd_pkg::LSD_PROT_OT_WAIT: begin
            if (overtemp_raw) begin
               state_d.prot = lsd_pkg::LSD_PROT_OT_HOT;
            end else if (wr_control) begin
               state_d.prot = lsd_pkg::LSD_PROT_RUN;
            end
         end
         default: begin
            state_d.prot = lsd_pkg::LSD_PROT_OT_HOT;
         end
      endcase

      // Driver gates, registered for glitch-free outputs
      // One cycle from the PWM, mode and fault inputs to the gates, two from a register write; PWM edges are delayed alike
      state_d.drv1 = lsd_drive(state_q.ctrl[lsd_pkg::LSD_CTL_DRV1_EN], drive_allowed,
                               lsd_pwm_gate(state_q.ctrl[lsd_pkg::LSD_CTL_DRV1_PWM_EN],
                                            state_q.ctrl[lsd_pkg::LSD_CTL_DRV1_SEL],
                                            pwm_ch0, pwm_ch1));
      state_d.drv2 = lsd_drive(state_q.ctrl[lsd_pkg::LSD_CTL_DRV2_EN], drive_allowed,
                               lsd_pwm_gate(state_q.ctrl[lsd_pkg::LSD_CTL_DRV2_PWM_EN],
                                            state_q.ctrl[lsd_pkg::LSD_CTL_DRV2_SEL],
                                            pwm_ch0, pwm_ch1));

      // Supply fault status and interrupts as registered copies
      // Request also needs the interrupt enable in control bit 7
      state_d.ov_cond = regulator_overvoltage;
      state_d.ov_irq  = ov_flag;
      state_d.ot_irq  = ot_flag & sink_irq_mask_bit
                      & state_q.ctrl[lsd_pkg::LSD_CTL_OT_IRQ_EN];

      // Read data captured on the read strobe, held otherwise
      // Only side effect of a read is the status flag clear
      if (reg_rd) begin
         case (reg_addr)
            lsd_pkg::LSD_OFS_CONTROL: begin
               state_d.rdata = state_q.ctrl;
            end
            lsd_pkg::LSD_OFS_STATUS: begin
               state_d.rdata = status_word;
            end
            lsd_pkg::LSD_OFS_UNLOCK: begin
               state_d.rdata = {4'h0, state_q.key};
            end
            default: begin
               state_d.rdata = 8'h00;   // Unmapped reads return zero
            end
         endcase
      end
   end

   // State register
   // Reset branch holds constants only
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q.ctrl    <= lsd_pkg::LSD_CONTROL_RESET;
         state_q.key     <= lsd_pkg::LSD_UNLOCK_RESET;
         state_q.prot    <= lsd_pkg::LSD_PROT_RUN;
         state_q.rdata   <= lsd_pkg::LSD_RDATA_RESET;
         state_q.drv1    <= 1'b0;
         state_q.drv2    <= 1'b0;
         state_q.ov_cond <= 1'b0;
         state_q.ov_irq  <= 1'b0;
         state_q.ot_irq  <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs straight from flip-flops
   // Unlock indication decodes the key register alone, so it cannot glitch on inputs
   assign reg_rdata                  = state_q.rdata;
   assign drv1_out                   = state_q.drv1;
   assign drv2_out                   = state_q.drv2;
   assign regulator_overvoltage_cond = state_q.ov_cond;
   assign regulator_overvoltage_irq  = state_q.ov_irq;
   assign sink_overtemp_irq_flag     = ot_flag;
   assign sink_irq_req               = state_q.ot_irq;
   assign control_unlocked           = key_ok;

endmodule

/* tb/lsd_top_chk.sv */
`timescale 1ns/1ps
module lsd_top_chk (
   // Clock and reset
   input logic       sys_clk,
   input logic       rst_b,
   // Register port and conditions
   input logic [7:0] reg_addr,
   input logic       reg_rd,
   input logic       normal_mode,
   input logic       overtemp_raw,
   input logic       regulator_overvoltage,
   input logic       regulator_overvoltage_irq_en,
   input logic       sink_irq_mask_bit,
   // Results
   input logic       regulator_overvoltage_cond,
   input logic       regulator_overvoltage_irq,
   input logic       sink_overtemp_irq_flag,
   input logic       sink_irq_req,
   input logic       drv1_out,
   input logic       drv2_out,
   input logic       control_unlocked
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Any blocking condition forces both gates low a cycle later
   AST_OT_OFF: assert property (overtemp_raw |=> !drv1_out && !drv2_out)
      else $error("gate on while hot");
   AST_KEY: assert property (!control_unlocked |=> !drv1_out && !drv2_out)
      else $error("gate on while locked");
   AST_OV_OFF: assert property (regulator_overvoltage |=> !drv1_out && !drv2_out)
      else $error("gate on in overvoltage");
   AST_MODE: assert property (!normal_mode |=> !drv1_out && !drv2_out)
      else $error("gate on outside normal mode");
   // Overvoltage status follows the condition; onset-only interrupt
   AST_OV_COND: assert property (regulator_overvoltage ##1 regulator_overvoltage
      |-> regulator_overvoltage_cond) else $error("overvoltage status dropped");
   AST_OV_CLR: assert property (!regulator_overvoltage ##1 !regulator_overvoltage
      |-> !regulator_overvoltage_cond) else $error("overvoltage status without condition");
   AST_OV_IRQ: assert property ($rose(regulator_overvoltage) && regulator_overvoltage_irq_en
      |-> ##[1:2] regulator_overvoltage_irq) else $error("no overvoltage interrupt");
   AST_OV_EDGE: assert property (regulator_overvoltage [*4] ##0 !regulator_overvoltage_irq
      |=> !regulator_overvoltage_irq) else $error("interrupt without onset");
   // Overtemperature flag, its clear and the masked request
   AST_OT_FLAG: assert property ($rose(overtemp_raw) |=> sink_overtemp_irq_flag)
      else $error("overtemperature not latched");
   AST_RD_CLR: assert property (reg_rd && reg_addr == lsd_pkg::LSD_OFS_STATUS && !$rose(overtemp_raw)
      |=> !sink_overtemp_irq_flag) else $error("flag kept after status read");
   AST_REQ: assert property (sink_irq_req
      |-> $past(sink_overtemp_irq_flag) && $past(sink_irq_mask_bit)) else $error("request without masked flag");
endmodule
bind lsd_top lsd_top_chk u_lsd_top_chk (.*);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] A_CTL = lsd_pkg::LSD_OFS_CONTROL;
   localparam logic [7:0] A_ST  = lsd_pkg::LSD_OFS_STATUS;
   localparam logic [7:0] A_KEY = lsd_pkg::LSD_OFS_UNLOCK;
   logic       sys_clk, rst_b, reg_wr, reg_rd, normal_mode, overtemp_raw, pwm_ch0, pwm_ch1;
   logic       drv1_open_load_raw, drv2_open_load_raw, drv1_current_limit_raw, drv2_current_limit_raw;
   logic       regulator_overvoltage, regulator_overvoltage_irq_en, vsr_cond_read, sink_irq_mask_bit;
   logic       regulator_overvoltage_cond, regulator_overvoltage_irq, sink_overtemp_irq_flag;
   logic       sink_irq_req, drv1_out, drv2_out, control_unlocked;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v, ctl, g;
   logic [31:0] rnd;
   int         bad_count, n_tests, seed, i;

   lsd_top u_lsd_top (.*);

   // Free-running bus clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data lands on the edge that takes the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      rd_v = reg_rdata;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Gate model: enable, mode and selected PWM channel; the key is taken as open
   function automatic logic [7:0] exp_gates(input logic [7:0] c, input logic ok, input logic p0, input logic p1);
      logic [7:0] r;
      r = 8'h00;
      for (int n = 0; n < 2; n++)
         r[n] = c[n] & ok & (c[n+2] ? (c[n+4] ? p1 : p0) : 1'b1);
      return r;
   endfunction

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles needed
   initial begin
      repeat (8000) @(posedge sys_clk);
      bad_count++;
      complete_run();
   end

   initial begin
      {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, overtemp_raw, pwm_ch0, pwm_ch1} = '0;
      {drv1_open_load_raw, drv2_open_load_raw, drv1_current_limit_raw, drv2_current_limit_raw} = '0;
      {regulator_overvoltage, regulator_overvoltage_irq_en, vsr_cond_read, sink_irq_mask_bit} = '0;
      normal_mode = 1'b1;
      seed = 27570;
      bad_count = 0;
      n_tests = 0;
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      for (i = 8'h30; i < 8'h34; i++) begin
         rd(i[7:0]);
         chk("reset_value", 8'h00, rd_v);
      end
      chk("unlock_reset", 8'h00, {7'h00, control_unlocked});
      $display("test reset done");
      // Enables are ignored until the key opens control
      wr(A_CTL, 8'h03);
      tick(2);
      chk("gates_locked", 8'h00, {6'h00, drv2_out, drv1_out});
      for (i = 0; i < 16; i++) begin
         rnd = $random(seed);
         wr(A_KEY, {rnd[7:4], i[3:0]});
         rd(A_KEY);
         chk("key", {4'h0, i[3:0]}, rd_v);
         chk("unlock", {7'h00, i == 5}, {7'h00, control_unlocked});
         chk("gates_key", {6'h00, {2{i == 5}}}, {6'h00, drv2_out, drv1_out});
      end
      wr(A_KEY, 8'h05);
      $display("test key done");
      // Random control, mode, PWM and sense inputs
      for (i = 0; i < 40; i++) begin
         rnd = $random(seed);
         wr(A_CTL, rnd[7:0]);
         @(posedge sys_clk);
         {pwm_ch1, pwm_ch0, drv2_current_limit_raw, drv1_current_limit_raw} <= rnd[13:10];
         {drv2_open_load_raw, drv1_open_load_raw} <= rnd[9:8];
         normal_mode <= rnd[14] | rnd[15];
         ctl = rnd[7:0] & lsd_pkg::LSD_CONTROL_WMASK;
         g = exp_gates(ctl, rnd[14] | rnd[15], rnd[12], rnd[13]);
         rd(A_CTL);
         chk("control", ctl, rd_v);
         chk("gates", g, {6'h00, drv2_out, drv1_out});
         rd(A_ST);
         chk("status", {4'h0, rnd[11:10], rnd[9:8] & g[1:0]}, rd_v);
      end
      $display("test random done");
      // Overtemperature shutdown, flag, request and restart
      @(posedge sys_clk);
      {pwm_ch1, pwm_ch0, drv2_current_limit_raw, drv1_current_limit_raw} <= 4'h0;
      {drv2_open_load_raw, drv1_open_load_raw, normal_mode, sink_irq_mask_bit} <= 4'h3;
      wr(A_CTL, 8'h83);
      @(posedge sys_clk);
      overtemp_raw <= 1'b1;
      tick(3);
      chk("gates_hot", 8'h00, {6'h00, drv2_out, drv1_out});
      chk("ot_flag_req", 8'h03, {6'h00, sink_overtemp_irq_flag, sink_irq_req});
      @(posedge sys_clk);
      sink_irq_mask_bit <= 1'b0;
      tick(2);
      chk("req_masked", 8'h00, {7'h00, sink_irq_req});
      rd(A_ST);
      chk("status_hot", 8'h80, rd_v);
      chk("flag_cleared", 8'h00, {7'h00, sink_overtemp_irq_flag});
      wr(A_CTL, 8'h83);
      @(posedge sys_clk);
      overtemp_raw <= 1'b0;
      tick(3);
      chk("gates_wait", 8'h00, {6'h00, drv2_out, drv1_out});
      wr(A_CTL, 8'h83);
      tick(2);
      chk("gates_rerun", 8'h03, {6'h00, drv2_out, drv1_out});
      $display("test overtemperature done");
      // Overvoltage clears enables; one interrupt per onset
      @(posedge sys_clk);
      regulator_overvoltage_irq_en <= 1'b1;
      regulator_overvoltage        <= 1'b1;
      tick(3);
      chk("gates_ov", 8'h00, {6'h00, drv2_out, drv1_out});
      chk("ov_state", 8'h03, {6'h00, regulator_overvoltage_cond, regulator_overvoltage_irq});
      rd(A_CTL);
      chk("ctl_ov", 8'h80, rd_v);
      @(posedge sys_clk);
      vsr_cond_read <= 1'b1;
      @(posedge sys_clk);
      vsr_cond_read <= 1'b0;
      tick(8);
      chk("ov_held", 8'h02, {6'h00, regulator_overvoltage_cond, regulator_overvoltage_irq});
      wr(A_KEY, 8'h05);
      wr(A_CTL, 8'h83);
      rd(A_CTL);
      chk("ctl_held", 8'h80, rd_v);
      @(posedge sys_clk);
      regulator_overvoltage <= 1'b0;
      tick(2);
      wr(A_CTL, 8'h83);
      tick(2);
      chk("gates_back", 8'h03, {6'h00, drv2_out, drv1_out});
      @(posedge sys_clk);
      regulator_overvoltage <= 1'b1;
      tick(3);
      chk("ov_again", 8'h03, {6'h00, regulator_overvoltage_cond, regulator_overvoltage_irq});
      chk("unlock_ov", 8'h00, {7'h00, control_unlocked});
      // Without a fresh key the enables stay powerless after the fault
      @(posedge sys_clk);
      regulator_overvoltage <= 1'b0;
      tick(2);
      wr(A_CTL, 8'h83);
      tick(2);
      chk("gates_relocked", 8'h00, {6'h00, drv2_out, drv1_out});
      $display("test overvoltage done");
      // Mid-run reset clears control, key and interrupt state
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(A_CTL);
      chk("ctl_after_reset", 8'h00, rd_v);
      rd(A_KEY);
      chk("key_after_reset", 8'h00, rd_v);
      chk("ov_after_reset", 8'h00, {6'h00, regulator_overvoltage_cond, regulator_overvoltage_irq});
      $display("test second reset done");
      complete_run();
   end
endmodule
